// ==== rtl/num_eff_cfg.svh ====
// Constants for the numeric effecter readback link and its two ends
`ifndef NUM_EFF_CFG_SVH
`define NUM_EFF_CFG_SVH
`define HANDLE_RSVD_LO 16'h0000
`define HANDLE_RSVD_HI 16'hffff
`define HANDLE_RST     16'h0001
`define CC_SUCCESS     8'h00
`define CC_BAD_HANDLE  8'h80
`define HDR_BYTES      4'h3
`define REG_HANDLE     4'h0
`define REG_CONFIG     4'h1
`define REG_MODE       4'h2
`define REG_PENDING    4'h3
`define REG_PRESENT    4'h4
`define REG_COND       4'h5
`define REG_DEFAULT    4'h6
`define REG_IRQ_STAT   4'h7
`define REG_IRQ_MASK   4'h8
`define CFG_FMT_LSB    0
`define CFG_DEF_BIT    8
`define MODE_ENABLED   2'h1
`define MODE_DISABLED  2'h2
`define MODE_UNAVAIL   2'h3
`define FMT_RST        3'h0
`define EV_ANSWER      0
`define EV_BAD_HANDLE  1
`define EV_REFUSED     2
`define EV_COND        3
`define CLK_NS         20
`define SETTLE_NS      1000
`define SHUT_NS        400
`define SETTLE_CYC     ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define SHUT_CYC       ((`SHUT_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ==== rtl/num_eff_pkg.sv ====
// Types and helpers shared by both ends of the effecter readback link
package num_eff_pkg;
   typedef enum logic [7:0] {FMT_U8, FMT_S8, FMT_U16, FMT_S16, FMT_U32, FMT_S32} fmt_t;
   typedef enum logic [7:0] {COND_EN_PEND, COND_EN_NOPEND, COND_DISABLED, COND_UNAVAIL,
                             COND_UNKNOWN, COND_FAILED, COND_INIT, COND_SHUTDOWN,
                             COND_IN_TEST} op_cond_t;

   // Bytes per setting field for a format code
   function automatic logic [3:0] fmt_bytes(input fmt_t fmt);
      unique case (fmt)
         FMT_U8, FMT_S8:   fmt_bytes = 4'h1;
         FMT_U16, FMT_S16: fmt_bytes = 4'h2;
         default:          fmt_bytes = 4'h4;
      endcase
   endfunction

   // Widen a received setting to 32 bits, sign aware
   function automatic logic [31:0] fmt_extend(input logic [31:0] raw, input fmt_t fmt);
      unique case (fmt)
         FMT_U8:  fmt_extend = {24'h000000, raw[7:0]};
         FMT_S8:  fmt_extend = {{24{raw[7]}}, raw[7:0]};
         FMT_U16: fmt_extend = {16'h0000, raw[15:0]};
         FMT_S16: fmt_extend = {{16{raw[15]}}, raw[15:0]};
         default: fmt_extend = raw;
      endcase
   endfunction
endpackage

// ==== rtl/num_eff_if.sv ====
// Byte link between requester and responder
`timescale 1ns/1ps
interface num_eff_if;
   logic       req_valid;
   logic [7:0] req_data;
   logic       rsp_valid;
   logic [7:0] rsp_data;
   logic       rsp_last;
   modport responder (input req_valid, input req_data,
                      output rsp_valid, output rsp_data, output rsp_last);
   modport requester (output req_valid, output req_data,
                      input rsp_valid, input rsp_data, input rsp_last);
endinterface

// ==== rtl/rsp_serializer.sv ====
// Response byte serializer for the responder end
`timescale 1ns/1ps
`include "num_eff_cfg.svh"
module rsp_serializer
   import num_eff_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire logic        err,
   input  wire logic [7:0]  cc,
   input  wire fmt_t        fmt,
   input  wire op_cond_t    cond,
   input  wire logic [31:0] pend,
   input  wire logic [31:0] pres,
   output logic             busy,
   output logic             out_valid,
   output logic [7:0]       out_data,
   output logic             out_last
);
   logic [7:0]  hdr [3];
   logic [31:0] pend_q;
   logic [31:0] pres_q;
   logic [3:0]  width;
   logic [3:0]  total;
   logic [3:0]  idx;
   logic [3:0]  k;
   logic [7:0]  next_byte;

   always_comb begin
      k = idx - `HDR_BYTES;
      if (idx < `HDR_BYTES) begin
         next_byte = hdr[idx[1:0]];
      end else if (k < width) begin
         next_byte = pend_q[{k[1:0], 3'b000} +: 8];
      end else begin
         next_byte = pres_q[{2'(k - width), 3'b000} +: 8];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hdr[0] <= 8'h00;
         hdr[1] <= 8'h00;
         hdr[2] <= 8'h00;
         pend_q <= 32'h00000000;
         pres_q <= 32'h00000000;
         width  <= 4'h0;
         total  <= 4'h0;
      end else if (start && !busy) begin
         hdr[0] <= cc;
         hdr[1] <= 8'(fmt);
         hdr[2] <= 8'(cond);
         pend_q <= pend;
         pres_q <= pres;
         width  <= fmt_bytes(fmt);
         total  <= err ? 4'h1 : 4'(`HDR_BYTES + 2 * fmt_bytes(fmt));
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         busy      <= 1'b0;
         idx       <= 4'h0;
         out_valid <= 1'b0;
         out_data  <= 8'h00;
         out_last  <= 1'b0;
      end else if (busy) begin
         out_valid <= 1'b1;
         out_data  <= next_byte;
         out_last  <= (idx == total - 4'h1);
         idx       <= idx + 4'h1;
         busy      <= (idx != total - 4'h1);
      end else begin
         out_valid <= 1'b0;
         out_last  <= 1'b0;
         idx       <= 4'h0;
         busy      <= start;
      end
   end
endmodule // rsp_serializer

// ==== rtl/eff_responder.sv ====
// Responder end: one numeric effecter, its condition and its readback answer
// Overview of operation
// - Request is 16-bit handle; unknown gets 0x80
// - Answer carries 8-bit format code, six choices
// - Both settings sized by returned format code
// - Answer carries 8-bit condition, nine ordered values
// - Update pending while setting still moving
// - No update pending: present in both fields
// - Other conditions: settings arbitrary, requester ignores
// - Disabled by enable control; no readings
// - Unavailable via enable control; requester ignores
// - Status unknown when no valid information
// - Failed when setting cannot be correct
// - Initializing while starting; requester ignores values
// - Shutting down while heading to disabled/failed/unavailable
// - In test while effecter under test
// - Disabled refuses updates; may revert default
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "num_eff_cfg.svh"
module eff_responder
   import num_eff_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   num_eff_if.responder     link,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   output logic             irq,
   input  wire logic        eff_failed,
   input  wire logic        eff_unknown,
   input  wire logic        eff_init,
   input  wire logic        eff_in_test
);
   logic [15:0] handle;
   fmt_t        fmt;
   logic        default_en;
   logic [1:0]  mode;
   logic [31:0] pending;
   logic [31:0] present;
   logic [31:0] default_val;
   op_cond_t    cond;
   op_cond_t    next_cond;
   logic [7:0]  settle_cnt;
   logic [7:0]  shut_cnt;
   logic        failed_q;
   logic        rx_half;
   logic [7:0]  rx_lo;
   logic        ser_start;
   logic        ser_err;
   logic        ser_busy;
   logic [3:0]  irq_stat;
   logic [3:0]  irq_mask;
   logic [3:0]  events;
   logic        wr_mode;
   logic        wr_pend;
   logic        leaving;
   logic        running;
   logic [15:0] rx_handle;

   assign wr_mode   = reg_wr && reg_addr == `REG_MODE &&
                      reg_wdata[1:0] != 2'h0;
   assign wr_pend   = reg_wr && reg_addr == `REG_PENDING;
   assign rx_handle = {link.req_data, rx_lo};
   // Failing or leaving enabled passes through a shutdown interval first
   assign leaving   = mode == `MODE_ENABLED &&
                      ((wr_mode && reg_wdata[1:0] != `MODE_ENABLED) ||
                       (eff_failed && !failed_q));
   assign running   = mode == `MODE_ENABLED && !eff_failed && !eff_in_test && !eff_init;

   always_comb begin
      if (eff_in_test) begin
         next_cond = COND_IN_TEST;
      end else if (shut_cnt != 8'h00) begin
         next_cond = COND_SHUTDOWN;
      end else if (eff_failed) begin
         next_cond = COND_FAILED;
      end else if (mode == `MODE_DISABLED) begin
         next_cond = COND_DISABLED;
      end else if (mode == `MODE_UNAVAIL) begin
         next_cond = COND_UNAVAIL;
      end else if (eff_init) begin
         next_cond = COND_INIT;
      end else if (eff_unknown) begin
         next_cond = COND_UNKNOWN;
      end else if (pending != present) begin
         next_cond = COND_EN_PEND;
      end else begin
         next_cond = COND_EN_NOPEND;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cond     <= COND_EN_NOPEND;
         failed_q <= 1'b0;
      end else begin
         cond     <= next_cond;
         failed_q <= eff_failed;
      end
   end

   // Configuration registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         handle      <= `HANDLE_RST;
         fmt         <= fmt_t'(`FMT_RST);
         default_en  <= 1'b0;
         default_val <= 32'h00000000;
         irq_mask    <= 4'h0;
      end else if (reg_wr) begin
         if (reg_addr == `REG_HANDLE) begin
            handle <= reg_wdata[15:0];
         end
         if (reg_addr == `REG_CONFIG && reg_wdata[`CFG_FMT_LSB +: 8] <= 8'(FMT_S32)) begin
            fmt        <= fmt_t'(reg_wdata[`CFG_FMT_LSB +: 8]);
            default_en <= reg_wdata[`CFG_DEF_BIT];
         end
         if (reg_addr == `REG_DEFAULT) begin
            default_val <= reg_wdata;
         end
         if (reg_addr == `REG_IRQ_MASK) begin
            irq_mask <= reg_wdata[3:0];
         end
      end
   end

   // Enable control; codes 1..3 follow the enable command, 0 is ignored
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mode <= `MODE_ENABLED;
      end else if (wr_mode) begin
         mode <= reg_wdata[1:0];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         shut_cnt <= 8'h00;
      end else if (leaving) begin
         shut_cnt <= 8'(`SHUT_CYC);
      end else if (shut_cnt != 8'h00) begin
         shut_cnt <= shut_cnt - 8'h01;
      end
   end

   // Setting: present follows pending after a settle time while running
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pending    <= 32'h00000000;
         present    <= 32'h00000000;
         settle_cnt <= 8'h00;
      end else if (wr_mode && reg_wdata[1:0] != `MODE_ENABLED && default_en) begin
         pending    <= default_val;
         present    <= default_val;
         settle_cnt <= 8'h00;
      end else if (wr_pend && mode == `MODE_ENABLED) begin
         pending    <= reg_wdata;
         settle_cnt <= 8'h00;
      end else if (running && pending != present) begin
         if (settle_cnt == 8'(`SETTLE_CYC - 1)) begin
            present    <= pending;
            settle_cnt <= 8'h00;
         end else begin
            settle_cnt <= settle_cnt + 8'h01;
         end
      end
   end

   // Request intake: low handle byte first; bytes during an answer are dropped
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rx_half   <= 1'b0;
         rx_lo     <= 8'h00;
         ser_start <= 1'b0;
         ser_err   <= 1'b0;
      end else begin
         ser_start <= 1'b0;
         if (link.req_valid && !ser_busy && !ser_start) begin
            if (!rx_half) begin
               rx_lo   <= link.req_data;
               rx_half <= 1'b1;
            end else begin
               rx_half   <= 1'b0;
               ser_start <= 1'b1;
               ser_err   <= rx_handle == `HANDLE_RSVD_LO || rx_handle == `HANDLE_RSVD_HI ||
                            rx_handle != handle;
            end
         end
      end
   end

   rsp_serializer u_ser (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .start     (ser_start),
      .err       (ser_err),
      .cc        (ser_err ? `CC_BAD_HANDLE : `CC_SUCCESS),
      .fmt       (fmt),
      .cond      (cond),
      // Pending field carries present when no update is pending; other conditions send values unmodified, the requester flags them
      .pend      (cond == COND_EN_NOPEND ? present : pending),
      .pres      (present),
      .busy      (ser_busy),
      .out_valid (link.rsp_valid),
      .out_data  (link.rsp_data),
      .out_last  (link.rsp_last)
   );

   assign events[`EV_ANSWER]     = ser_start;
   assign events[`EV_BAD_HANDLE] = ser_start && ser_err;
   assign events[`EV_REFUSED]    = wr_pend && mode != `MODE_ENABLED;
   assign events[`EV_COND]       = next_cond != cond;

   // Set wins over the clearing read so no event is lost
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_stat <= 4'h0;
      end else if (reg_rd && reg_addr == `REG_IRQ_STAT) begin
         irq_stat <= events;
      end else begin
         irq_stat <= irq_stat | events;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_mask);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `REG_HANDLE:   reg_rdata <= {16'h0000, handle};
            `REG_CONFIG:   reg_rdata <= {23'h000000, default_en, 8'(fmt)};
            `REG_MODE:     reg_rdata <= {30'h00000000, mode};
            `REG_PENDING:  reg_rdata <= pending;
            `REG_PRESENT:  reg_rdata <= present;
            `REG_COND:     reg_rdata <= {24'h000000, 8'(cond)};
            `REG_DEFAULT:  reg_rdata <= default_val;
            `REG_IRQ_STAT: reg_rdata <= {28'h0000000, irq_stat};
            `REG_IRQ_MASK: reg_rdata <= {28'h0000000, irq_mask};
            default:       reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end
endmodule // eff_responder

// ==== rtl/eff_requester.sv ====
// Requester end: sends a handle and parses the readback answer
`timescale 1ns/1ps
`include "num_eff_cfg.svh"
module eff_requester
   import num_eff_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   num_eff_if.requester     link,
   input  wire logic        cmd_start,
   input  wire logic [15:0] cmd_handle,
   output logic             busy,
   output logic             done,
   output logic [7:0]       cc,
   output fmt_t             fmt,
   output op_cond_t         cond,
   output logic [31:0]      pending,
   output logic [31:0]      present,
   output logic             values_valid,
   output logic             ignore_effecter
);
   typedef enum logic [1:0] {ST_IDLE, ST_SEND_HI, ST_RECV} req_state_t;
   req_state_t  state;
   logic [15:0] hold;
   logic [3:0]  idx;
   logic [3:0]  width;
   logic [3:0]  k;
   logic [31:0] raw_pend;
   logic [31:0] raw_pres;
   logic        fin;

   assign k = idx - `HDR_BYTES;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state          <= ST_IDLE;
         hold           <= 16'h0000;
         link.req_valid <= 1'b0;
         link.req_data  <= 8'h00;
         busy           <= 1'b0;
      end else begin
         link.req_valid <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (cmd_start) begin
                  hold           <= cmd_handle;
                  link.req_valid <= 1'b1;
                  link.req_data  <= cmd_handle[7:0];
                  busy           <= 1'b1;
                  state          <= ST_SEND_HI;
               end
            end
            ST_SEND_HI: begin
               link.req_valid <= 1'b1;
               link.req_data  <= hold[15:8];
               state          <= ST_RECV;
            end
            ST_RECV: begin
               if (link.rsp_valid && link.rsp_last) begin
                  busy  <= 1'b0;
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Response parse; field positions follow the returned format code
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         idx      <= 4'h0;
         width    <= 4'h1;
         raw_pend <= 32'h00000000;
         raw_pres <= 32'h00000000;
         cc       <= 8'h00;
         fmt      <= FMT_U8;
         cond     <= COND_EN_NOPEND;
      end else if (state != ST_RECV) begin
         idx <= 4'h0;
      end else if (link.rsp_valid) begin
         idx <= idx + 4'h1;
         if (idx == 4'h0) begin
            cc       <= link.rsp_data;
            raw_pend <= 32'h00000000;
            raw_pres <= 32'h00000000;
         end else if (idx == 4'h1) begin
            fmt   <= fmt_t'(link.rsp_data);
            width <= fmt_bytes(fmt_t'(link.rsp_data));
         end else if (idx == 4'h2) begin
            cond <= op_cond_t'(link.rsp_data);
         end else if (k < width) begin
            raw_pend[{k[1:0], 3'b000} +: 8] <= link.rsp_data;
         end else begin
            raw_pres[{2'(k - width), 3'b000} +: 8] <= link.rsp_data;
         end
      end
   end

   // Results land one cycle after the last byte, once that byte is in raw_pres
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fin             <= 1'b0;
         done            <= 1'b0;
         pending         <= 32'h00000000;
         present         <= 32'h00000000;
         values_valid    <= 1'b0;
         ignore_effecter <= 1'b0;
      end else begin
         fin  <= state == ST_RECV && link.rsp_valid && link.rsp_last;
         done <= fin;
         if (fin) begin
            pending      <= fmt_extend(raw_pend, fmt);
            present      <= fmt_extend(raw_pres, fmt);
            values_valid <= cc == `CC_SUCCESS &&
                            (cond == COND_EN_PEND || cond == COND_EN_NOPEND);
            if (cc == `CC_SUCCESS) begin
               ignore_effecter <= cond == COND_UNAVAIL;
            end
         end
      end
   end
endmodule // eff_requester

// ==== test/link_monitor.sv ====
// Protocol checks on the effecter readback link
`timescale 1ns/1ps
module link_monitor (
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       req_valid,
   input wire logic [7:0] req_data,
   input wire logic       rsp_valid,
   input wire logic [7:0] rsp_data,
   input wire logic       rsp_last
);
   logic [3:0] rcnt;
   logic [7:0] fmt_q;
   logic [7:0] lo_q;
   logic       qhalf;
   logic       rsvd_q;

   function automatic logic [4:0] nb(input logic [7:0] f);
      nb = (f < 8'h02) ? 5'h01 : (f < 8'h04) ? 5'h02 : 5'h04;
   endfunction

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rcnt <= 4'h0;
         fmt_q <= 8'h00;
      end else if (rsp_valid) begin
         rcnt <= rsp_last ? 4'h0 : rcnt + 4'h1;
         if (rcnt == 4'h1) fmt_q <= rsp_data;
      end
   end

   // Handle bytes both 00 or both ff mark a reserved handle in either byte order
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         qhalf <= 1'b0;
         lo_q <= 8'h00;
         rsvd_q <= 1'b0;
      end else if (req_valid) begin
         qhalf <= ~qhalf;
         if (!qhalf) lo_q <= req_data;
         if (qhalf) rsvd_q <= (lo_q == req_data) && (req_data == 8'h00 || req_data == 8'hff);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence handle_done;
      req_valid && qhalf;
   endsequence
   sequence first_rsp;
      rsp_valid && (rcnt == 4'h0);
   endsequence

   last_with_valid_a: assert property (rsp_last |-> rsp_valid)
      else $error("last flag without valid byte");
   err_cc_alone_a: assert property (first_rsp and rsp_data != 8'h00 |-> rsp_last)
      else $error("error answer longer than one byte");
   ok_cc_more_a: assert property (first_rsp and rsp_data == 8'h00 |-> !rsp_last)
      else $error("success answer ends at completion code");
   fmt_code_range_a: assert property (rsp_valid && rcnt == 4'h1 |-> rsp_data <= 8'h05)
      else $error("format code out of range");
   cond_code_range_a: assert property (rsp_valid && rcnt == 4'h2 |-> rsp_data <= 8'h08)
      else $error("condition code out of range");
   len_by_fmt_a: assert property (rsp_valid && rsp_last && rcnt != 4'h0
      |-> {1'b0, rcnt} + 5'h01 == 5'h03 + 2 * nb(fmt_q))
      else $error("setting fields do not match format width");
   reserved_handle_a: assert property (first_rsp and rsvd_q |-> rsp_data == 8'h80)
      else $error("reserved handle not refused");
   answer_bound_a: assert property (handle_done |-> ##[1:1000] first_rsp)
      else $error("no answer to a complete request");
   no_rsp_midreq_a: assert property (first_rsp |-> !qhalf)
      else $error("answer begins before handle complete");
endmodule // link_monitor

// ==== test/numeric_effecter_value_readback_bench.sv ====
// Self-checking bench joining requester and responder ends
`timescale 1ns/1ps
`include "num_eff_cfg.svh"
module numeric_effecter_value_readback_bench import num_eff_pkg::*;;
   logic        sys_clk, rst, reg_wr, reg_rd, irq, cmd_start;
   logic        busy, done, values_valid, ignore_effecter;
   logic [3:0]  reg_addr, ev;
   logic [31:0] reg_wdata, reg_rdata, pending, present, v, d, p0;
   logic [15:0] cmd_handle, h;
   logic [7:0]  cc;
   logic [7:0]  cap [3];
   fmt_t        fmt;
   op_cond_t    cond;
   int          mismatches, n_compared, rlen, rcnt, qcnt;
   logic        a, b;
   op_cond_t    ev_cond [4] = '{COND_FAILED, COND_UNKNOWN, COND_INIT, COND_IN_TEST};
   logic [15:0] bad [3];

   num_eff_if bus ();
   eff_responder u_eff_responder (.sys_clk(sys_clk), .rst(rst), .link(bus),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .eff_failed(ev[0]), .eff_unknown(ev[1]),
      .eff_init(ev[2]), .eff_in_test(ev[3]));
   eff_requester u_eff_requester (.sys_clk(sys_clk), .rst(rst), .link(bus),
      .cmd_start(cmd_start), .cmd_handle(cmd_handle), .busy(busy), .done(done), .cc(cc),
      .fmt(fmt), .cond(cond), .pending(pending), .present(present),
      .values_valid(values_valid), .ignore_effecter(ignore_effecter));
   link_monitor u_link_monitor (.sys_clk(sys_clk), .rst(rst), .req_valid(bus.req_valid),
      .req_data(bus.req_data), .rsp_valid(bus.rsp_valid), .rsp_data(bus.rsp_data),
      .rsp_last(bus.rsp_last));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Wire watch: bytes per answer and the three header bytes
   always @(posedge sys_clk) begin
      if (!rst && bus.req_valid === 1'b1) qcnt++;
      if (!rst && bus.rsp_valid === 1'b1) begin
         if (rcnt < 3) cap[rcnt] = bus.rsp_data;
         rcnt++;
         if (bus.rsp_last === 1'b1) begin
            rlen = rcnt;
            rcnt = 0;
         end
      end
   end

   function automatic int nb(input fmt_t f);
      nb = (f < FMT_U16) ? 1 : (f < FMT_U32) ? 2 : 4;
   endfunction

   function automatic logic [31:0] ext(input logic [31:0] r, input fmt_t f);
      case (f)
         FMT_U8:  ext = {24'h000000, r[7:0]};
         FMT_S8:  ext = {{24{r[7]}}, r[7:0]};
         FMT_U16: ext = {16'h0000, r[15:0]};
         FMT_S16: ext = {{16{r[15]}}, r[15:0]};
         default: ext = r;
      endcase
   endfunction

   task automatic end_sim;
      if (mismatches == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic wr(input logic [3:0] ad, input logic [31:0] dat);
      @(posedge sys_clk);
      reg_addr <= ad;
      reg_wdata <= dat;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] ad, output logic [31:0] dat);
      @(posedge sys_clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 dat = reg_rdata;
   endtask

   // One readback; a hang counts as a mismatch
   task automatic ask(input logic [15:0] hd);
      int q0, k;
      q0 = qcnt;
      @(posedge sys_clk);
      cmd_start <= 1'b1;
      cmd_handle <= hd;
      @(posedge sys_clk);
      cmd_start <= 1'b0;
      for (k = 0; k < 2000; k++) begin
         @(posedge sys_clk);
         #1;
         if (k == 0) check({31'h0, busy}, 32'h1);
         if (done === 1'b1) break;
      end
      if (k == 2000) begin
         mismatches++;
         end_sim();
      end
      check({31'h0, busy}, 32'h0);
      check(32'(qcnt - q0), 32'd2);
   endtask

   task automatic expect_rsp(input logic [7:0] c, input fmt_t f, input op_cond_t co,
                             input logic vv);
      check({24'h0, cc}, {24'h0, c});
      check({24'h0, cap[0]}, {24'h0, c});
      if (c != `CC_SUCCESS) begin
         check(32'(rlen), 32'd1);
         check({31'h0, values_valid}, 32'h0);
      end else begin
         check({24'h0, fmt}, {24'h0, f});
         check({24'h0, cond}, {24'h0, co});
         check({24'h0, cap[1]}, {24'h0, f});
         check({24'h0, cap[2]}, {24'h0, co});
         check(32'(rlen), 32'(3 + 2 * nb(f)));
         check({31'h0, values_valid}, {31'h0, vv});
      end
   endtask

   initial begin
      rst = 1'b1;
      {reg_addr, reg_wdata, reg_wr, reg_rd, ev, cmd_start, cmd_handle} = '0;
      {mismatches, n_compared, rlen, rcnt, qcnt} = '0;
      void'($urandom(7100));
      cyc(16);
      rst <= 1'b0;
      h = 16'h0100 + 16'($urandom_range(32'h7e00));
      bad = '{`HANDLE_RSVD_LO, `HANDLE_RSVD_HI, h + 16'h0001};
      wr(`REG_IRQ_MASK, 32'h0);
      wr(`REG_HANDLE, {16'h0, h});
      wr(`REG_MODE, {30'h0, `MODE_ENABLED});
      cyc(`SETTLE_CYC + 5);
      for (int i = 0; i < 6; i++) begin
         v = (i == 1) ? 32'hffffff80 : ext($urandom, fmt_t'(i));
         wr(`REG_CONFIG, 32'(i));
         wr(`REG_PENDING, v);
         ask(h);
         expect_rsp(`CC_SUCCESS, fmt_t'(i), COND_EN_PEND, 1'b1);
         check(pending, v);
         cyc(`SETTLE_CYC + 5);
         ask(h);
         expect_rsp(`CC_SUCCESS, fmt_t'(i), COND_EN_NOPEND, 1'b1);
         check(pending, v);
         check(present, v);
      end
      foreach (bad[k]) begin
         ask(bad[k]);
         expect_rsp(`CC_BAD_HANDLE, FMT_U8, COND_EN_PEND, 1'b0);
      end
      // Mask polarity is the designer's; only the toggle is judged
      wr(`REG_IRQ_MASK, 32'h0);
      cyc(2);
      a = irq;
      wr(`REG_IRQ_MASK, 32'hffffffff);
      cyc(2);
      b = irq;
      check({31'h0, a ^ b}, 32'h1);
      wr(`REG_IRQ_MASK, a ? 32'h0 : 32'hffffffff);
      rd(`REG_IRQ_STAT, d);
      check({31'h0, d[`EV_BAD_HANDLE]}, 32'h1);
      rd(`REG_IRQ_STAT, d);
      check({31'h0, d[`EV_BAD_HANDLE]}, 32'h0);
      cyc(2);
      check({31'h0, irq}, 32'h0);
      for (int k = 0; k < 4; k++) begin
         @(posedge sys_clk);
         ev <= 4'h1 << k;
         cyc(5);
         // A fresh failure first passes through the shutdown interval
         rd(`REG_COND, d);
         check({24'h0, d[7:0]}, {24'h0, (k == 0) ? COND_SHUTDOWN : ev_cond[k]});
         cyc(`SHUT_CYC);
         ask(h);
         expect_rsp(`CC_SUCCESS, FMT_S32, ev_cond[k], 1'b0);
         @(posedge sys_clk);
         ev <= 4'h0;
         cyc(`SETTLE_CYC + 5);
      end
      wr(`REG_MODE, {30'h0, `MODE_UNAVAIL});
      cyc(`SETTLE_CYC + 5);
      ask(h);
      expect_rsp(`CC_SUCCESS, FMT_S32, COND_UNAVAIL, 1'b0);
      check({31'h0, ignore_effecter}, 32'h1);
      wr(`REG_MODE, {30'h0, `MODE_ENABLED});
      cyc(`SETTLE_CYC + 5);
      ask(h);
      expect_rsp(`CC_SUCCESS, FMT_S32, COND_EN_NOPEND, 1'b1);
      check({31'h0, ignore_effecter}, 32'h0);
      wr(`REG_MODE, {30'h0, `MODE_DISABLED});
      rd(`REG_COND, d);
      check({24'h0, d[7:0]}, {24'h0, COND_SHUTDOWN});
      cyc(`SHUT_CYC + 5);
      ask(h);
      expect_rsp(`CC_SUCCESS, FMT_S32, COND_DISABLED, 1'b0);
      rd(`REG_PENDING, p0);
      rd(`REG_IRQ_STAT, d);
      wr(`REG_PENDING, ~p0);
      cyc(2);
      check({31'h0, irq}, 32'h1);
      rd(`REG_IRQ_STAT, d);
      check({31'h0, d[`EV_REFUSED]}, 32'h1);
      rd(`REG_PENDING, d);
      check(d, p0);
      end_sim();
   end
endmodule // numeric_effecter_value_readback_bench
